// ===== src/fcct_pkg.sv
package fcct_pkg;

  // ****************************************************************
  // Machine cycle and prescaler timing
  // ****************************************************************
  localparam int unsigned CLK_PER_MCYCLE = 4;
  localparam logic [1:0]  PH_FIRST       = 2'h0;
  localparam logic [1:0]  PH_LAST        = 2'h3;
  localparam int unsigned TMR_DIV_LEGACY = 12;
  localparam int unsigned TMR_DIV_FAST   = 4;
  localparam int unsigned NUM_TIMERS     = 3;

  // ****************************************************************
  // Instruction cycle counts in machine cycles; shortest strobe width in clocks
  // ****************************************************************
  localparam logic [3:0] CYC_ONE_BYTE   = 4'h1;
  localparam logic [3:0] CYC_TABLE_READ = 4'h3;
  localparam logic [3:0] CYC_DP_INC     = 4'h3;
  localparam logic [3:0] CYC_MUL_DIV    = 4'h5;
  localparam logic [3:0] CYC_XDM_MIN    = 4'h2;
  localparam logic [4:0] STB_MIN_CLK    = 5'h02;

  // ****************************************************************
  // Special function registers
  // ****************************************************************
  localparam logic [7:0] SFR_PTR_SEL    = 8'h86;
  localparam logic [7:0] SFR_TMR_SPEED  = 8'h8E;
  localparam int unsigned PSEL_BIT      = 0;
  localparam int unsigned SPD_LSB       = 3;
  localparam int unsigned STR_LSB       = 0;
  localparam logic [2:0] SPD_RESET      = 3'h0;
  localparam logic [2:0] STR_RESET      = 3'h1;

  typedef enum logic [2:0] {
    FCCT_OP_REG,
    FCCT_OP_TABLE_READ,
    FCCT_OP_DP_INC,
    FCCT_OP_MULTIPLY,
    FCCT_OP_DIVIDE,
    FCCT_OP_XDM
  } fcct_class_t;

endpackage

// ===== src/fcct_tick_if.sv
`timescale 1ns/1ps
interface fcct_tick_if;
  logic [2:0] speed_fast;
  logic [2:0] tick;
  modport pre  (input speed_fast, output tick);
  modport core (output speed_fast, input tick);
endinterface

// ===== src/fcct_prescaler.sv
`timescale 1ns/1ps
module fcct_prescaler #(
  parameter int unsigned DIV_SLOW = fcct_pkg::TMR_DIV_LEGACY,
  parameter int unsigned DIV_FAST = fcct_pkg::TMR_DIV_FAST
) (
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  fcct_tick_if.pre   tk
);

  // ****************************************************************
  // Free-running divider
  // ****************************************************************
  // The divider never restarts on a speed change, so switching a
  // timer's rate only changes which ticks it sees, never its count.
  logic [3:0] div_ff;
  logic       slow_tick;
  logic       fast_tick;
  logic [2:0] tick_ff;

  assign slow_tick = (div_ff == 4'(DIV_SLOW - 1));
  assign fast_tick = (div_ff[1:0] == 2'(DIV_FAST - 1));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_ff <= 4'h0;
    end else if (slow_tick) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_ff <= 3'h0;
    end else begin
      for (int i = 0; i < fcct_pkg::NUM_TIMERS; i++) begin
        tick_ff[i] <= tk.speed_fast[i] ? fast_tick : slow_tick; // [RULE3] [RULE13]
      end
    end
  end

  assign tk.tick = tick_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_slow_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE13]
    slow_tick |=> !slow_tick [*8] ##1 !slow_tick ##1 !slow_tick ##1 !slow_tick ##1 slow_tick)
    else $error("slow prescale tick not every twelve clocks");
  a_fast_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3]
    fast_tick |=> !fast_tick [*3] ##1 fast_tick)
    else $error("fast prescale tick not every four clocks");

endmodule

// ===== src/fcct_core_timing.sv
`timescale 1ns/1ps
// What this block does
// [RULE1] Each machine cycle lasts exactly four oscillator clocks.
// [RULE2] One address-latch strobe pulse is given in every machine cycle.
// [RULE3] Timers tick every twelve clocks after reset and every four when selected fast.
// [RULE4] External data moves last two to nine machine cycles, set by the stretch field.
// [RULE5] Timing alone differs from the legacy core; results and flags are not touched here.
// [RULE6] Ordinary instructions spend one machine cycle per opcode byte.
// [RULE7] The shortest external data move takes two machine cycles.
// [RULE8] A three-byte instruction takes three machine cycles.
// [RULE9] Multiply and divide take five machine cycles, the longest of any fixed-length instruction.
// [RULE10] Two data pointers exist so block moves alternate without saving addresses.
// [RULE11] Bit 0 of register 86h picks the active pointer; its other bits read zero.
// [RULE12] Bits 5, 4, 3 of the timer speed register pick fast timing for timers 2, 1, 0.
// [RULE13] The timer prescaler free-runs and a rate change never disturbs a timer.
module fcct_core_timing (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                instr_valid,
  output logic                     instr_ready,
  input  wire fcct_pkg::fcct_class_t instr_class,
  input  wire logic [1:0]          instr_bytes,
  output logic                     instr_busy,
  output logic                     instr_done,
  output logic                     addr_latch_stb,
  output logic [1:0]               mcycle_phase,
  output logic                     xdm_strobe,
  input  wire logic                sfr_wr_en,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [7:0]          sfr_wr_data,
  output logic [7:0]               sfr_rd_data,
  input  wire logic                data_pointer_load,
  input  wire logic [15:0]         data_pointer_load_data,
  input  wire logic                data_pointer_inc,
  output logic [15:0]              data_pointer,
  output logic                     pointer_select_bit,
  output logic [2:0]               timer_tick
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [3:0] cycles_for(fcct_pkg::fcct_class_t cls,
                                            logic [1:0] nbytes, logic [2:0] stretch);
    logic [3:0] n;
    n = fcct_pkg::CYC_ONE_BYTE;
    unique case (cls)
      fcct_pkg::FCCT_OP_REG:        n = (nbytes == 2'h0) ? fcct_pkg::CYC_ONE_BYTE
                                                         : {2'h0, nbytes};
      fcct_pkg::FCCT_OP_TABLE_READ: n = fcct_pkg::CYC_TABLE_READ;
      fcct_pkg::FCCT_OP_DP_INC:     n = fcct_pkg::CYC_DP_INC;
      fcct_pkg::FCCT_OP_MULTIPLY,
      fcct_pkg::FCCT_OP_DIVIDE:     n = fcct_pkg::CYC_MUL_DIV;
      fcct_pkg::FCCT_OP_XDM:        n = fcct_pkg::CYC_XDM_MIN + {1'h0, stretch};
      default:                      n = fcct_pkg::CYC_ONE_BYTE;
    endcase
    return n;
  endfunction

  function automatic logic [4:0] strobe_width(logic [2:0] stretch);
    return (stretch == 3'h0) ? fcct_pkg::STB_MIN_CLK : {stretch, 2'h0};
  endfunction

  // ****************************************************************
  // Machine cycle phase and address latch
  // ****************************************************************
  logic [1:0] phase_ff;
  logic       ale_ff;
  logic       mc_end;

  assign mc_end = (phase_ff == fcct_pkg::PH_LAST);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase_ff <= fcct_pkg::PH_FIRST;
    end else begin
      phase_ff <= phase_ff + 2'h1; // [RULE1]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ale_ff <= 1'b1;
    end else begin
      ale_ff <= mc_end; // [RULE2]
    end
  end

  assign addr_latch_stb = ale_ff;
  assign mcycle_phase   = phase_ff;

  // ****************************************************************
  // Special function registers
  // ****************************************************************
  logic       psel_ff;
  logic [2:0] speed_ff;
  logic [2:0] stretch_ff;
  logic [7:0] rd_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      psel_ff <= 1'b0;
    end else if (sfr_wr_en && sfr_addr == fcct_pkg::SFR_PTR_SEL) begin
      psel_ff <= sfr_wr_data[fcct_pkg::PSEL_BIT]; // [RULE11]
    end
  end

  // A stretch change during a move takes effect on the next move only,
  // because the cycle count is latched when the move is accepted.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      speed_ff   <= fcct_pkg::SPD_RESET; // [RULE12]
      stretch_ff <= fcct_pkg::STR_RESET;
    end else if (sfr_wr_en && sfr_addr == fcct_pkg::SFR_TMR_SPEED) begin
      speed_ff   <= sfr_wr_data[fcct_pkg::SPD_LSB +: 3]; // [RULE12]
      stretch_ff <= sfr_wr_data[fcct_pkg::STR_LSB +: 3]; // [RULE4]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_ff <= 8'h00;
    end else if (sfr_addr == fcct_pkg::SFR_PTR_SEL) begin
      rd_ff <= {7'h00, psel_ff}; // [RULE11]
    end else if (sfr_addr == fcct_pkg::SFR_TMR_SPEED) begin
      rd_ff <= {2'h0, speed_ff, stretch_ff};
    end else begin
      rd_ff <= 8'h00;
    end
  end

  assign sfr_rd_data        = rd_ff;
  assign pointer_select_bit = psel_ff;

  // ****************************************************************
  // Dual data pointer
  // ****************************************************************
  logic [15:0] dp_ff [2];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dp_ff[0] <= 16'h0000;
      dp_ff[1] <= 16'h0000;
    end else if (data_pointer_load) begin
      dp_ff[psel_ff] <= data_pointer_load_data; // [RULE10]
    end else if (data_pointer_inc) begin
      dp_ff[psel_ff] <= dp_ff[psel_ff] + 16'h0001; // [RULE10]
    end
  end

  assign data_pointer = dp_ff[psel_ff];

  // ****************************************************************
  // Instruction sequencer
  // ****************************************************************
  // Only cycle counts are decided here; the datapath keeps legacy results. [RULE5]
  logic       busy_ff;
  logic       done_ff;
  logic       xdm_ff;
  logic       first_ff;
  logic [3:0] left_ff;
  logic [4:0] stb_ff;
  logic [2:0] xdm_str_ff;
  logic       take;

  assign instr_ready = mc_end && (!busy_ff || left_ff == 4'h1);
  assign take        = instr_valid && instr_ready;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      left_ff <= 4'h0;
    end else if (take) begin
      busy_ff <= 1'b1;
      left_ff <= cycles_for(instr_class, instr_bytes, stretch_ff); // [RULE6] [RULE8] [RULE9]
    end else if (busy_ff && mc_end) begin
      busy_ff <= (left_ff != 4'h1);
      left_ff <= left_ff - 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= busy_ff && mc_end && left_ff == 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      xdm_ff     <= 1'b0;
      first_ff   <= 1'b0;
      xdm_str_ff <= fcct_pkg::STR_RESET;
    end else if (take) begin
      xdm_ff     <= (instr_class == fcct_pkg::FCCT_OP_XDM);
      first_ff   <= 1'b1;
      xdm_str_ff <= stretch_ff; // [RULE4]
    end else if (mc_end) begin
      first_ff <= 1'b0;
    end
  end

  // The strobe opens after the address cycle and always closes before the move ends.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stb_ff <= 5'h00;
    end else if (busy_ff && xdm_ff && first_ff && mc_end) begin
      stb_ff <= strobe_width(xdm_str_ff); // [RULE4] [RULE7]
    end else if (stb_ff != 5'h00) begin
      stb_ff <= stb_ff - 5'h01;
    end
  end

  assign instr_busy = busy_ff;
  assign instr_done = done_ff;
  assign xdm_strobe = (stb_ff != 5'h00);

  // ****************************************************************
  // Timer prescaler
  // ****************************************************************
  fcct_tick_if tk_if ();

  assign tk_if.speed_fast = speed_ff; // [RULE3]
  assign timer_tick       = tk_if.tick;

  fcct_prescaler u_prescaler (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tk      (tk_if.pre)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_phase_wrap: assert property (mcycle_phase == 2'h3 |=> mcycle_phase == 2'h0) // [RULE1]
    else $error("machine cycle not four clocks");
  a_ale_once: assert property (addr_latch_stb |=> !addr_latch_stb [*3] ##1 addr_latch_stb) // [RULE2]
    else $error("address latch not once per machine cycle");
  a_one_byte_time: assert property (take && instr_class == fcct_pkg::FCCT_OP_REG // [RULE6]
    && instr_bytes == 2'h1 |-> ##2 !instr_done [*3] ##1 instr_done)
    else $error("one-byte instruction not four clocks");
  a_three_byte_time: assert property (take && instr_class == fcct_pkg::FCCT_OP_REG // [RULE8]
    && instr_bytes == 2'h3 |-> ##13 instr_done)
    else $error("three-byte instruction not twelve clocks");
  a_muldiv_time: assert property (take && (instr_class == fcct_pkg::FCCT_OP_MULTIPLY // [RULE9]
    || instr_class == fcct_pkg::FCCT_OP_DIVIDE) |-> ##21 instr_done)
    else $error("multiply or divide not twenty clocks");
  a_xdm_min_time: assert property (take && instr_class == fcct_pkg::FCCT_OP_XDM // [RULE7]
    && stretch_ff == 3'h0 |-> ##9 instr_done)
    else $error("shortest external move not eight clocks");
  a_xdm_range: assert property (take && instr_class == fcct_pkg::FCCT_OP_XDM // [RULE4]
    |-> ##[9:37] instr_done)
    else $error("external move outside two to nine cycles");
  a_psel_read: assert property (sfr_addr == fcct_pkg::SFR_PTR_SEL // [RULE11]
    |=> sfr_rd_data[7:1] == 7'h00 && sfr_rd_data[0] == $past(psel_ff))
    else $error("pointer select register reads wrong");
  a_dp_switch: assert property (sfr_wr_en && sfr_addr == fcct_pkg::SFR_PTR_SEL // [RULE10]
    && !data_pointer_load && !data_pointer_inc |=> data_pointer == $past(dp_ff[sfr_wr_data[0]]))
    else $error("active data pointer did not follow select");
  a_tick_select: assert property ($past(speed_ff[0]) == 1'b0 && timer_tick[0] // [RULE3]
    |=> (!timer_tick[0] || $past(speed_ff[0])) [*8])
    else $error("legacy timer rate ticked early");

  c_xdm_long: cover property (take && instr_class == fcct_pkg::FCCT_OP_XDM
    && stretch_ff == 3'h7);
  c_back_to_back: cover property (instr_done && busy_ff);
  c_fast_timer: cover property (speed_ff[2] && timer_tick[2]);

endmodule

// ===== testbench/fcct_xmem_model.sv
`timescale 1ns/1ps
module fcct_xmem_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       xdm_strobe,
  output logic      [7:0] strobe_width,
  output logic      [7:0] strobe_count
);
  logic [7:0] run_ff;

  // The memory acts on the closing strobe edge, so the bench sees the width only once it ends.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      run_ff       <= 8'h00;
      strobe_width <= 8'h00;
      strobe_count <= 8'h00;
    end else if (xdm_strobe) begin
      run_ff <= run_ff + 8'h01;
    end else if (run_ff != 8'h00) begin
      strobe_width <= run_ff;
      strobe_count <= strobe_count + 8'h01;
      run_ff       <= 8'h00;
    end
  end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  instr_valid = 1'b0;
  logic                  instr_ready, instr_busy, instr_done, addr_latch_stb, xdm_strobe;
  fcct_pkg::fcct_class_t instr_class = fcct_pkg::FCCT_OP_REG;
  logic [1:0]            instr_bytes = 2'h1;
  logic [1:0]            mcycle_phase;
  logic                  sfr_wr_en = 1'b0;
  logic [7:0]            sfr_addr = 8'h00;
  logic [7:0]            sfr_wr_data = 8'h00;
  logic [7:0]            sfr_rd_data, strobe_width, strobe_count;
  logic                  data_pointer_load = 1'b0;
  logic                  data_pointer_inc = 1'b0;
  logic [15:0]           data_pointer_load_data = 16'h0000;
  logic [15:0]           data_pointer, pa, pb;
  logic                  pointer_select_bit;
  logic [2:0]            timer_tick, spd;
  int                    errors = 0;
  int                    tests_run = 0;
  int                    cyc = 0;
  logic [31:0]           seed = 32'h95669E98;
  int                    k, m, n, st;
  int                    cnt [3];

  always #2 ref_clk = ~ref_clk;

  fcct_core_timing dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_class(instr_class), .instr_bytes(instr_bytes),
    .instr_busy(instr_busy), .instr_done(instr_done), .addr_latch_stb(addr_latch_stb),
    .mcycle_phase(mcycle_phase), .xdm_strobe(xdm_strobe), .sfr_wr_en(sfr_wr_en),
    .sfr_addr(sfr_addr), .sfr_wr_data(sfr_wr_data), .sfr_rd_data(sfr_rd_data),
    .data_pointer_load(data_pointer_load), .data_pointer_load_data(data_pointer_load_data), .data_pointer_inc(data_pointer_inc),
    .data_pointer(data_pointer), .pointer_select_bit(pointer_select_bit),
    .timer_tick(timer_tick));

  fcct_xmem_model xmem (.ref_clk(ref_clk), .rst_n(rst_n), .xdm_strobe(xdm_strobe),
    .strobe_width(strobe_width), .strobe_count(strobe_count));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Edges from the taking edge to the done pulse, as the core's cycle counts dictate.
  function automatic int exp_lat(fcct_pkg::fcct_class_t c, logic [1:0] b, int s);
    int mc;
    case (c)
      fcct_pkg::FCCT_OP_REG:        mc = (b == 2'h0) ? 1 : int'(b);
      fcct_pkg::FCCT_OP_TABLE_READ: mc = 3;
      fcct_pkg::FCCT_OP_DP_INC:     mc = 3;
      fcct_pkg::FCCT_OP_XDM:        mc = 2 + s;
      default:                      mc = 5;
    endcase
    return 4 * mc + 1;
  endfunction

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wr_data = d;
    sfr_wr_en = 1'b1;
    step();
    sfr_wr_en = 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    step();
    d = sfr_rd_data;
  endtask

  task automatic run_instr(input fcct_pkg::fcct_class_t c, input logic [1:0] b, input int s);
    int w;
    instr_class = c;
    instr_bytes = b;
    instr_valid = 1'b1;
    w = 0;
    while (instr_ready !== 1'b1 && w < 40) begin
      step();
      w++;
    end
    step();
    instr_valid = 1'b0;
    `CHK("busy_start", 1'b1, instr_busy)
    w = 1;
    while (instr_done !== 1'b1 && w < 60) begin
      step();
      w++;
    end
    `CHK("done_latency", exp_lat(c, b, s), w)
    `CHK("busy_end", 1'b0, instr_busy)
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    logic [7:0] rd;
    step();
    step();
    rst_n = 1'b1;
    // ****************************************************************
    // Reset values and register map
    // ****************************************************************
    sfr_rd(fcct_pkg::SFR_TMR_SPEED, rd);
    `CHK("speed_reset", 8'h01, rd)
    sfr_rd(fcct_pkg::SFR_PTR_SEL, rd);
    `CHK("select_reset", 8'h00, rd)
    sfr_rd(8'h55, rd);
    `CHK("unmapped", 8'h00, rd)
    // ****************************************************************
    // Machine cycle framing
    // ****************************************************************
    m = 0;
    for (k = 0; k < 40; k++) begin
      n = int'(mcycle_phase);
      step();
      if (addr_latch_stb === 1'b1) m++;
      `CHK("phase_step", 2'((n + 1) % 4), mcycle_phase)
    end
    `CHK("ale_count", 10, m)
    // ****************************************************************
    // Stretched external moves, every setting
    // ****************************************************************
    for (st = 0; st < 8; st++) begin
      n = int'(strobe_count);
      sfr_wr(fcct_pkg::SFR_TMR_SPEED, 8'(st));
      run_instr(fcct_pkg::FCCT_OP_XDM, 2'h1, st);
      step();
      `CHK("strobe_width", 8'((st == 0) ? 2 : 4 * st), strobe_width)
      `CHK("strobe_count", 8'(n + 1), strobe_count)
    end
    // ****************************************************************
    // Random instruction mix, back to back
    // ****************************************************************
    st = int'(rnd() % 8);
    sfr_wr(fcct_pkg::SFR_TMR_SPEED, 8'(st));
    for (k = 0; k < 24; k++) begin
      run_instr(fcct_pkg::fcct_class_t'(3'(rnd() % 6)), 2'(rnd()), st);
    end
    run_instr(fcct_pkg::FCCT_OP_MULTIPLY, 2'h1, st);
    run_instr(fcct_pkg::FCCT_OP_DIVIDE, 2'h1, st);
    run_instr(fcct_pkg::FCCT_OP_REG, 2'h3, st);
    run_instr(fcct_pkg::FCCT_OP_REG, 2'h0, st);
    // Request held high, so the second operation is taken in the first one's last cycle.
    instr_class = fcct_pkg::FCCT_OP_REG;
    instr_bytes = 2'h1;
    instr_valid = 1'b1;
    while (instr_ready !== 1'b1) begin
      step();
    end
    repeat (5) begin
      step();
    end
    instr_valid = 1'b0;
    `CHK("b2b_first_done", 1'b1, instr_done)
    `CHK("b2b_second_busy", 1'b1, instr_busy)
    repeat (4) begin
      step();
    end
    `CHK("b2b_second_done", 1'b1, instr_done)
    `CHK("b2b_idle", 1'b0, instr_busy)
    // ****************************************************************
    // Dual data pointer
    // ****************************************************************
    pa = 16'(rnd());
    pb = 16'(rnd());
    data_pointer_load_data = pa;
    data_pointer_load = 1'b1;
    step();
    data_pointer_load = 1'b0;
    sfr_wr(fcct_pkg::SFR_PTR_SEL, 8'hFF);
    sfr_rd(fcct_pkg::SFR_PTR_SEL, rd);
    `CHK("select_read", 8'h01, rd)
    `CHK("select_bit", 1'b1, pointer_select_bit)
    `CHK("ptr1_clear", 16'h0000, data_pointer)
    data_pointer_load_data = pb;
    data_pointer_load = 1'b1;
    data_pointer_inc = 1'b1;
    step();
    data_pointer_load = 1'b0;
    step();
    data_pointer_inc = 1'b0;
    step();
    `CHK("ptr1_inc", 16'(pb + 16'h0001), data_pointer)
    sfr_wr(fcct_pkg::SFR_PTR_SEL, 8'hFE);
    `CHK("ptr0_kept", pa, data_pointer)
    // ****************************************************************
    // Timer rates, changed on the fly
    // ****************************************************************
    for (m = 0; m < 5; m++) begin
      spd = (m == 0) ? 3'h0 : 3'(rnd());
      sfr_wr(fcct_pkg::SFR_TMR_SPEED, {2'h0, spd, 3'h1});
      step();
      step();
      cnt = '{0, 0, 0};
      for (k = 0; k < 48; k++) begin
        step();
        for (n = 0; n < 3; n++) if (timer_tick[n] === 1'b1) cnt[n]++;
      end
      for (n = 0; n < 3; n++) begin
        `CHK("tick_count", spd[n] ? 12 : 4, cnt[n])
      end
    end
    end_sim();
  end
endmodule
